// [arc_pkg.sv]
// arc_pkg: constants shared by the asynchronous register output cell array
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package arc_pkg;
    // ========================================================
    // sizes
    localparam int ARC_NCELL = 10;
    localparam int ARC_NTERM = 4;
    localparam int ARC_NIN = 10;
    // ========================================================
    // reset, clear and preset values, synchroniser depth
    localparam logic ARC_Q_RST = 1'h0;
    localparam logic ARC_PRESET_VAL = 1'h1;
    localparam logic ARC_CLEAR_VAL = 1'h0;
    localparam logic ARC_PIN_RST = 1'h0;
    localparam logic ARC_OE_N_RST = 1'h1;
    localparam logic ARC_OE_PIN_N_RST = 1'h1;
    localparam int ARC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// [arc_output_cell.sv]
// arc_output_cell: ten output cells, each a d flip-flop with its own
// clock, clear and preset product terms, polarity xor, bypass and
// three-state control; product terms arrive from array logic on mclk,
// pins are synchronised here before use
//
// Notes on behaviour
// - ten flip-flops, own clear, preset, clock
// - four terms summed through polarity xor
// - output enable from term and shared pin
// - each cell may bypass its flip-flop
// - capture on own clock term edge
// - up to ten independent clocks
// - any term true gives d equal polarity
// - polarity ignored by clear and preset
// - ten dedicated inputs, ten bidirectional pins
`timescale 1ns/1ps
`default_nettype none
module arc_output_cell
    import arc_pkg::*;
#(
    parameter int NCELL = arc_pkg::ARC_NCELL,
    parameter int NTERM = arc_pkg::ARC_NTERM,
    parameter int NIN = arc_pkg::ARC_NIN
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NCELL*NTERM-1:0] pt_data,
    input wire logic [NCELL-1:0] pt_clk,
    input wire logic [NCELL-1:0] pt_clear,
    input wire logic [NCELL-1:0] pt_preset,
    input wire logic [NCELL-1:0] pt_oe,
    input wire logic [NCELL-1:0] polarity,
    input wire logic [NCELL-1:0] bypass,
    input wire logic oe_pin_n,
    input wire logic [NIN-1:0] in_pin,
    input wire logic [NCELL-1:0] io_in,
    output logic [NCELL-1:0] io_out,
    output logic [NCELL-1:0] io_oe_n,
    output logic [NIN-1:0] array_in,
    output logic [NCELL-1:0] io_fb,
    output logic [NCELL-1:0] reg_fb
);
    import arc_pkg::*;

    // ========================================================
    // helper functions

    // data input of one cell
    function automatic logic cell_d(input logic [NTERM-1:0] terms,
                                    input logic pol);
        cell_d = (|terms) ? pol : ~pol;
    endfunction

    // clear beats preset; otherwise the given value stands
    function automatic logic forced_or(input logic clr,
                                       input logic pre,
                                       input logic other);
        if (clr) begin
            forced_or = ARC_CLEAR_VAL;
        end else if (pre) begin
            forced_or = ARC_PRESET_VAL;
        end else begin
            forced_or = other;
        end
    endfunction

    // rising edge of a clock term between two mclk samples
    function automatic logic term_rise(input logic prev,
                                       input logic now);
        term_rise = now & ~prev;
    endfunction

    // ========================================================
    // dedicated input synchroniser
    logic [NIN-1:0] in_s1_q, in_s1_d;
    logic [NIN-1:0] in_s2_q, in_s2_d;

    always_comb begin
        in_s1_d = in_pin;
        in_s2_d = in_s1_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
        end else begin
            in_s1_q <= in_s1_d;
            in_s2_q <= in_s2_d;
        end
    end

    assign array_in = in_s2_q;

    // ========================================================
    // two-way pin input synchroniser
    logic [NCELL-1:0] io_s1_q, io_s1_d;
    logic [NCELL-1:0] io_s2_q, io_s2_d;

    always_comb begin
        io_s1_d = io_in;
        io_s2_d = io_s1_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_s1_q <= '0;
            io_s2_q <= '0;
        end else begin
            io_s1_q <= io_s1_d;
            io_s2_q <= io_s2_d;
        end
    end

    assign io_fb = io_s2_q;

    // ========================================================
    // shared output enable synchroniser
    logic oe_s1_q, oe_s1_d;
    logic oe_s2_q, oe_s2_d;

    always_comb begin
        oe_s1_d = oe_pin_n;
        oe_s2_d = oe_s1_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_s1_q <= ARC_OE_PIN_N_RST;
            oe_s2_q <= ARC_OE_PIN_N_RST;
        end else begin
            oe_s1_q <= oe_s1_d;
            oe_s2_q <= oe_s2_d;
        end
    end

    // ========================================================
    // per-cell data input, clock edge and state feedback
    logic [NCELL-1:0] q_q, q_d;
    logic [NCELL-1:0] clk_prev_q, clk_prev_d;
    logic [NCELL-1:0] d_in;
    logic [NCELL-1:0] rise;
    logic [NCELL-1:0] q_eff;

    genvar g;
    generate
        for (g = 0; g < NCELL; g++) begin : g_cell
            assign d_in[g] = cell_d(pt_data[g*NTERM +: NTERM], polarity[g]);
            // each cell watches only its own clock term
            assign rise[g] = term_rise(clk_prev_q[g], pt_clk[g]);
            // clear and preset act without waiting for a clock edge
            assign q_eff[g] = forced_or(pt_clear[g],
                                        pt_preset[g],
                                        q_q[g]);
        end
    endgenerate

    assign reg_fb = q_eff;

    // ========================================================
    // clock term edge detector
    always_comb begin
        clk_prev_d = pt_clk;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= '0;
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // ========================================================
    // cell flip-flops
    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            // a clock edge under clear or preset is ignored
            q_d[i] = forced_or(pt_clear[i], pt_preset[i],
                               rise[i] ? d_in[i] : q_q[i]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= {NCELL{ARC_Q_RST}};
        end else begin
            q_q <= q_d;
        end
    end

    // ========================================================
    // pin value
    logic [NCELL-1:0] out_q, out_d;

    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            out_d[i] = bypass[i] ? d_in[i] : q_d[i];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= {NCELL{ARC_PIN_RST}};
        end else begin
            out_q <= out_d;
        end
    end

    assign io_out = out_q;

    // ========================================================
    // pin enable
    logic [NCELL-1:0] oe_n_q, oe_n_d;

    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            // drive only with both enables true
            oe_n_d[i] = ~(pt_oe[i] & ~oe_s2_q);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_q <= {NCELL{ARC_OE_N_RST}};
        end else begin
            oe_n_q <= oe_n_d;
        end
    end

    assign io_oe_n = oe_n_q;
endmodule
`default_nettype wire

// [arc_chk_sva.sv]
// arc_chk_sva: port timing checks for the output cell array
// assumes default sizes; bound to every arc_output_cell
`timescale 1ns/1ps
`default_nettype none
module arc_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [39:0] pt_data,
    input wire logic [9:0] pt_clk,
    input wire logic [9:0] pt_clear,
    input wire logic [9:0] pt_preset,
    input wire logic [9:0] pt_oe,
    input wire logic [9:0] polarity,
    input wire logic [9:0] bypass,
    input wire logic oe_pin_n,
    input wire logic [9:0] io_out,
    input wire logic [9:0] io_oe_n,
    input wire logic [9:0] reg_fb
);
    logic [9:0] d, cq, cap;
    always_comb
        for (int g = 0; g < 10; g++) d[g] = (|pt_data[4*g+:4]) ~^ polarity[g];
    always_ff @(posedge mclk) cq <= pt_clk;
    assign cap = pt_clk & ~cq & ~pt_clear & ~pt_preset;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_CLR: assert property ((reg_fb & pt_clear) == 0) else $error("clr");
    AST_PRE: assert property ((~reg_fb & pt_preset & ~pt_clear) == 0)
        else $error("preset");
    AST_BYP: assert property ($past(rst_n) |->
        ((io_out ^ $past(d)) & $past(bypass)) == 0) else $error("bypass");
    AST_REG: assert property ($past(rst_n) |-> ((io_out ^ reg_fb) &
        ~$past(bypass) & ~pt_clear & ~pt_preset) == 0) else $error("reg");
    AST_CAP: assert property ($past(rst_n, 2) |-> ((reg_fb ^ $past(d)) &
        $past(cap) & ~(pt_clear | pt_preset)) == 0) else $error("cap");
    AST_HOLD: assert property ($past(rst_n, 2) |-> ((reg_fb ^ $past(reg_fb)) &
        ~$past(cap | pt_clear | pt_preset) & ~(pt_clear | pt_preset)) == 0)
        else $error("hold");
    AST_OE: assert property ($past(rst_n, 3) |-> io_oe_n ==
        ~($past(pt_oe) & {10{!$past(oe_pin_n, 3)}})) else $error("oe");
    AST_OFF: assert property ($past(oe_pin_n, 3) |-> &io_oe_n)
        else $error("off");
endmodule
bind arc_output_cell arc_chk chk (.*);
`default_nettype wire

// [arc_pin_model.sv]
// arc_pin_model: far side of the ten two-way pins
// assumes the bench feeds a changing pattern for released pins
`timescale 1ns/1ps
`default_nettype none
module arc_pin_model (
    input wire logic [9:0] io_out,
    input wire logic [9:0] io_oe_n,
    input wire logic [9:0] ext,
    output logic [9:0] io_in
);
    assign io_in = (io_out & ~io_oe_n) | (ext & io_oe_n);
endmodule
`default_nettype wire

// [tb_top.sv]
// tb_top: random and corner stimulus for arc_output_cell
// assumes arc_pkg, the checker and the pin model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 0, rst_n = 0, oe_pin_n = 1;
    logic [39:0] pt_data = '0;
    logic [9:0] pt_clk = '0, pt_clear = '0, pt_preset = '0, pt_oe = '0;
    logic [9:0] polarity = '0, bypass = '0, in_pin = '0, ext = '0;
    wire logic [9:0] io_in, io_out, io_oe_n, array_in, io_fb, reg_fb;
    int errors = 0, total_checks = 0;
    logic [9:0] held;
    arc_output_cell dut (.*);
    arc_pin_model pins (.*);
    initial forever #10 mclk = ~mclk;
    function automatic logic [9:0] exp_d(logic [39:0] t, logic [9:0] p);
        for (int g = 0; g < 10; g++) exp_d[g] = (|t[4*g+:4]) ~^ p[g];
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h6810541b));
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        repeat (200) begin
            @(posedge mclk);
            {pt_clk, pt_data, polarity, bypass, pt_oe, oe_pin_n, in_pin, ext}
                <= 101'({$urandom, $urandom, $urandom, $urandom});
            {pt_clear, pt_preset} <= 20'($urandom & $urandom & $urandom);
        end
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            {pt_clk, pt_clear, pt_preset} <= '0;
            pt_data <= 40'({$urandom, $urandom} & {$urandom, $urandom});
            polarity <= 10'($urandom);
            bypass <= 10'($urandom);
            @(posedge mclk);
            pt_clk <= '1;
            @(posedge mclk);
            held = exp_d(pt_data, polarity);
            pt_data <= 40'({$urandom, $urandom});
            #1 check(reg_fb, held);
            @(posedge mclk);
            #1 check(io_out, (held & ~bypass) |
                     (exp_d(pt_data, polarity) & bypass));
        end
        @(posedge mclk);
        {pt_clear, pt_preset} <= {10'h0f3, 10'h3ff};
        #1 check(reg_fb, 10'h30c);
        @(posedge mclk);
        {pt_clear, pt_preset, pt_oe} <= '0;
        in_pin <= 10'($urandom);
        ext <= 10'($urandom);
        repeat (4) @(posedge mclk);
        #1 check(array_in, in_pin);
        check(io_fb, ext);
        check(io_oe_n, 10'h3ff);
        held = (10'h30c & ~bypass) | (exp_d(pt_data, polarity) & bypass);
        @(posedge mclk);
        pt_oe <= '1;
        oe_pin_n <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 check(io_oe_n, 10'h000);
        check(io_out, held);
        check(io_fb, held);
        report_and_stop;
    end
endmodule
`default_nettype wire
